// ---- core/aux_branch_pkg.sv ----
package aux_branch_pkg;

  // ------------------------------------------------------------------
  // opcode bytes
  // ------------------------------------------------------------------
  localparam logic [7:0]  OP_ACC_PREFIX  = 8'hfd;
  localparam logic [7:0]  OP_ACC_SECOND  = 8'h28;
  localparam logic [7:0]  OP_FILE_PREFIX = 8'hdd;
  localparam logic [7:0]  OP_FILE_SECOND = 8'h20;

  // ------------------------------------------------------------------
  // widths and reset values
  // ------------------------------------------------------------------
  localparam int          PC_W           = 16;
  localparam int          DISP_W         = 8;
  localparam logic [15:0] INSTR_LEN      = 16'h0003;
  localparam logic [15:0] PC_RESET       = 16'h0000;

  typedef enum logic [2:0] {
    S_IDLE,
    S_ACC_PREFIX,
    S_FILE_PREFIX,
    S_ACC_DISP,
    S_FILE_DISP
  } dec_state_t;

endpackage

// ---- core/rel_target_calc.sv ----
`timescale 1ns/10ps
module rel_target_calc (
  input  wire logic [15:0] instr_addr_in,
  input  wire logic [7:0]  disp_in,
  output logic      [15:0] next_pc_out,
  output logic      [15:0] target_out
);
  import aux_branch_pkg::*;

  wire logic [15:0] disp_ext;

  // relative base is the address just past the three-byte instruction
  assign next_pc_out = instr_addr_in + INSTR_LEN;
  assign disp_ext    = {{(PC_W - DISP_W){disp_in[DISP_W-1]}}, disp_in};
  assign target_out  = next_pc_out + disp_ext;

endmodule

// ---- core/aux_bank_relative_branch.sv ----
`timescale 1ns/10ps
// Summary of operation
// - alt acc branch taken only with alt pair
// - alt file branch taken only with alt file
// - taken loads target, else next instruction
// - target is next instruction address plus sign-extended displacement
// - decode fd 28 disp and dd 20 disp
module aux_bank_relative_branch (
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        byte_valid_in,
  input  wire logic [7:0]  byte_in,
  input  wire logic [15:0] byte_addr_in,
  input  wire logic        alt_acc_flag_sel_in,
  input  wire logic        alt_reg_file_sel_in,
  output logic             busy_out,
  output logic             done_out,
  output logic             pc_load_out,
  output logic [15:0]      pc_next_out,
  output logic             flag_write_out,
  output logic             exception_out
);
  import aux_branch_pkg::*;

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  dec_state_t  state_q;
  dec_state_t  state_d;
  logic [15:0] instr_addr_q;
  logic        done_q;
  logic        pc_load_q;
  logic [15:0] pc_next_q;

  wire logic        is_acc_prefix;
  wire logic        is_file_prefix;
  wire logic        in_disp;
  wire logic        cond_true;
  wire logic        disp_take;
  wire logic [15:0] seq_pc;
  wire logic [15:0] rel_target;

  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  assign is_acc_prefix  = byte_in == OP_ACC_PREFIX;
  assign is_file_prefix = byte_in == OP_FILE_PREFIX;
  assign in_disp        = (state_q == S_ACC_DISP) || (state_q == S_FILE_DISP);
  assign disp_take      = in_disp && byte_valid_in;
  assign cond_true      = (state_q == S_ACC_DISP) ? alt_acc_flag_sel_in
                                                  : alt_reg_file_sel_in;

  rel_target_calc u_calc (
    .instr_addr_in (instr_addr_q),
    .disp_in       (byte_in),
    .next_pc_out   (seq_pc),
    .target_out    (rel_target)
  );

  always_comb begin
    state_d = state_q;
    if (byte_valid_in) begin
      case (state_q)
        S_IDLE: begin
          if (is_acc_prefix) begin
            state_d = S_ACC_PREFIX;
          end else if (is_file_prefix) begin
            state_d = S_FILE_PREFIX;
          end
        end
        S_ACC_PREFIX: begin
          state_d = (byte_in == OP_ACC_SECOND) ? S_ACC_DISP : S_IDLE;
        end
        S_FILE_PREFIX: begin
          state_d = (byte_in == OP_FILE_SECOND) ? S_FILE_DISP : S_IDLE;
        end
        S_ACC_DISP: begin
          state_d = S_IDLE;
        end
        S_FILE_DISP: begin
          state_d = S_IDLE;
        end
        default: begin
          state_d = S_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      state_q <= S_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // start address is caught with the first opcode byte
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      instr_addr_q <= PC_RESET;
    end else if (byte_valid_in && state_q == S_IDLE) begin
      instr_addr_q <= byte_addr_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      done_q    <= 1'b0;
      pc_load_q <= 1'b0;
      pc_next_q <= PC_RESET;
    end else begin
      done_q    <= disp_take;
      pc_load_q <= disp_take && cond_true;
      if (disp_take) begin
        pc_next_q <= cond_true ? rel_target : seq_pc;
      end
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign busy_out       = state_q != S_IDLE;
  assign done_out       = done_q;
  assign pc_load_out    = pc_load_q;
  assign pc_next_out    = pc_next_q;
  assign flag_write_out = 1'b0;
  assign exception_out  = 1'b0;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  sequence acc_disp_seen;
    state_q == S_ACC_DISP && byte_valid_in;
  endsequence

  sequence file_disp_seen;
    state_q == S_FILE_DISP && byte_valid_in;
  endsequence

  sequence acc_opcode_pair;
    state_q == S_IDLE && byte_valid_in && byte_in == OP_ACC_PREFIX
      ##1 byte_valid_in && byte_in == OP_ACC_SECOND;
  endsequence

  sequence file_opcode_pair;
    state_q == S_IDLE && byte_valid_in && byte_in == OP_FILE_PREFIX
      ##1 byte_valid_in && byte_in == OP_FILE_SECOND;
  endsequence

  a_acc_cond_load: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    acc_disp_seen |=> done_out && (pc_load_out == $past(alt_acc_flag_sel_in)))
    else $error("alt pair branch load mismatch");

  a_file_cond_load: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    file_disp_seen |=> done_out && (pc_load_out == $past(alt_reg_file_sel_in)))
    else $error("alt file branch load mismatch");

  a_fall_through_pc: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (disp_take && !cond_true) |=> pc_next_out == $past(instr_addr_q) + INSTR_LEN)
    else $error("fall-through pc not next instruction");

  a_target_value: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (disp_take && cond_true) |=> pc_next_out == $past(instr_addr_q) + INSTR_LEN
      + {{8{$past(byte_in[7])}}, $past(byte_in)})
    else $error("branch target wrong");

  a_acc_decode: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    acc_opcode_pair |=> state_q == S_ACC_DISP)
    else $error("alt pair opcode not decoded");

  a_file_decode: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    file_opcode_pair |=> state_q == S_FILE_DISP)
    else $error("alt file opcode not decoded");

  a_done_only_disp: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    done_out |-> $past(disp_take) ##1 !done_out || $past(disp_take))
    else $error("done without displacement byte");

  a_no_flag_trap: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    !flag_write_out && !exception_out)
    else $error("flag write or exception raised");

  a_load_needs_done: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    pc_load_out |-> done_out)
    else $error("pc load without completion");

  sequence wrong_second_byte;
    byte_valid_in && ((state_q == S_ACC_PREFIX && byte_in != OP_ACC_SECOND)
      || (state_q == S_FILE_PREFIX && byte_in != OP_FILE_SECOND));
  endsequence

  a_busy_on_prefix: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (state_q == S_IDLE && byte_valid_in && (is_acc_prefix || is_file_prefix)) |=> busy_out)
    else $error("prefix byte did not start a sequence");

  a_bad_second_abort: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    wrong_second_byte |=> state_q == S_IDLE)
    else $error("wrong second byte did not abort");

  a_pc_next_hold: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    !disp_take |=> $stable(pc_next_out))
    else $error("pc next moved without a branch");

endmodule

// ---- test/aux_bank_relative_branch_tb.sv ----
`timescale 1ns/10ps
module aux_bank_relative_branch_tb;
  import aux_branch_pkg::*;

  logic        clk_in;
  logic        rst_b_in;
  logic        byte_valid_in;
  logic [7:0]  byte_in;
  logic [15:0] byte_addr_in;
  logic        alt_acc_flag_sel_in;
  logic        alt_reg_file_sel_in;
  logic        busy_out;
  logic        done_out;
  logic        pc_load_out;
  logic [15:0] pc_next_out;
  logic        flag_write_out;
  logic        exception_out;
  int          n_fail;
  int          num_checks;

  aux_bank_relative_branch u_dut (
    .clk_in              (clk_in),
    .rst_b_in            (rst_b_in),
    .byte_valid_in       (byte_valid_in),
    .byte_in             (byte_in),
    .byte_addr_in        (byte_addr_in),
    .alt_acc_flag_sel_in (alt_acc_flag_sel_in),
    .alt_reg_file_sel_in (alt_reg_file_sel_in),
    .busy_out            (busy_out),
    .done_out            (done_out),
    .pc_load_out         (pc_load_out),
    .pc_next_out         (pc_next_out),
    .flag_write_out      (flag_write_out),
    .exception_out       (exception_out)
  );

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // inputs change 1 ns after each rising edge
  task automatic put_byte(input logic [7:0] b, input logic [15:0] a);
    byte_valid_in = 1'b1;
    byte_in       = b;
    byte_addr_in  = a;
    @(posedge clk_in);
    #1;
  endtask

  // three bytes, then done is due in the cycle right after the disp edge
  task automatic run_seq(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
                         input logic [15:0] a, input logic acc, input logic fil,
                         input logic exp_done, input logic exp_load, input logic [15:0] exp_pc);
    alt_acc_flag_sel_in = acc;
    alt_reg_file_sel_in = fil;
    put_byte(b0, a);
    check(busy_out === 1'b1, "busy after prefix");
    put_byte(b1, a + 16'h0001);
    put_byte(b2, a + 16'h0002);
    byte_valid_in = 1'b0;
    check(done_out === exp_done, "done pulse");
    check(pc_load_out === exp_load, "pc load");
    check(pc_next_out === exp_pc, "pc next");
    check(flag_write_out === 1'b0 && exception_out === 1'b0, "flag or exception");
    check(busy_out === 1'b0, "busy after last byte");
    @(posedge clk_in);
    #1;
    check(done_out === 1'b0 && pc_load_out === 1'b0, "pulse too long");
    check(pc_next_out === exp_pc, "pc next held");
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_acc_branch();
    run_seq(8'hfd, 8'h28, 8'h1a, 16'h4fe3, 1'b1, 1'b0, 1'b1, 1'b1, 16'h5000);
    run_seq(8'hfd, 8'h28, 8'h1a, 16'h4fe3, 1'b0, 1'b1, 1'b1, 1'b0, 16'h4fe6);
  endtask

  task automatic t_file_branch();
    run_seq(8'hdd, 8'h20, 8'hda, 16'h42f3, 1'b0, 1'b1, 1'b1, 1'b1, 16'h42d0);
    run_seq(8'hdd, 8'h20, 8'hda, 16'h42f3, 1'b1, 1'b0, 1'b1, 1'b0, 16'h42f6);
  endtask

  task automatic t_disp_limits();
    run_seq(8'hfd, 8'h28, 8'h7f, 16'h0000, 1'b1, 1'b1, 1'b1, 1'b1, 16'h0082);
    run_seq(8'hdd, 8'h20, 8'h80, 16'h0000, 1'b1, 1'b1, 1'b1, 1'b1, 16'hff83);
  endtask

  // crossed second bytes must abort and leave the last target standing
  task automatic t_bad_second();
    run_seq(8'hfd, 8'h20, 8'h00, 16'h1000, 1'b1, 1'b1, 1'b0, 1'b0, 16'hff83);
    run_seq(8'hdd, 8'h28, 8'h00, 16'h1000, 1'b1, 1'b1, 1'b0, 1'b0, 16'hff83);
  endtask

  // gaps between bytes are legal; the select only counts with the disp byte
  task automatic t_gapped();
    alt_acc_flag_sel_in = 1'b0;
    alt_reg_file_sel_in = 1'b0;
    put_byte(8'hfd, 16'h2000);
    byte_valid_in = 1'b0;
    @(posedge clk_in);
    #1;
    check(busy_out === 1'b1, "busy over gap");
    put_byte(8'h28, 16'h2001);
    byte_valid_in = 1'b0;
    @(posedge clk_in);
    #1;
    check(done_out === 1'b0, "done before disp byte");
    alt_acc_flag_sel_in = 1'b1;
    put_byte(8'hfe, 16'h2002);
    byte_valid_in = 1'b0;
    check(done_out === 1'b1 && pc_load_out === 1'b1, "gapped branch taken");
    check(pc_next_out === 16'h2001, "gapped target");
    @(posedge clk_in);
    #1;
    check(done_out === 1'b0 && pc_load_out === 1'b0, "gapped pulse too long");
  endtask

  // reset in mid sequence drops the prefix and clears the held target
  task automatic t_mid_reset();
    put_byte(8'hdd, 16'h3000);
    byte_valid_in = 1'b0;
    rst_b_in      = 1'b0;
    @(posedge clk_in);
    #1;
    rst_b_in = 1'b1;
    check(busy_out === 1'b0 && pc_next_out === PC_RESET, "reset in mid sequence");
    alt_reg_file_sel_in = 1'b1;
    put_byte(8'h20, 16'h3001);
    put_byte(8'h05, 16'h3002);
    byte_valid_in = 1'b0;
    check(done_out === 1'b0 && pc_load_out === 1'b0, "branch after reset");
    check(pc_next_out === PC_RESET, "target after reset");
  endtask

  // ------------------------------------------------------------------
  // clock, reset and main sequence
  // ------------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  initial begin
    #100000;
    n_fail++;
    $display("unexpected at %0t: run timed out", $time);
    give_verdict();
  end

  initial begin
    n_fail              = 0;
    num_checks          = 0;
    rst_b_in            = 1'b0;
    byte_valid_in       = 1'b0;
    byte_in             = 8'h00;
    byte_addr_in        = 16'h0000;
    alt_acc_flag_sel_in = 1'b0;
    alt_reg_file_sel_in = 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
    rst_b_in = 1'b1;
    check(done_out === 1'b0 && busy_out === 1'b0, "reset outputs");
    check(pc_next_out === PC_RESET, "reset pc next");
    t_acc_branch();
    t_file_branch();
    t_disp_limits();
    t_bad_second();
    t_gapped();
    t_mid_reset();
    give_verdict();
  end
endmodule
